/* File: logic/stack_exec_defines.svh */
// constants for the stack, return and rotate executor
// assumes a byte-wide register file and a four-bit c/z/s/v flag bus
`ifndef STACK_EXEC_DEFINES_SVH
`define STACK_EXEC_DEFINES_SVH

`define OPC_READ_DOWN 8'h92
`define OPC_READ_UP 8'h93
`define OPC_STORE_DOWN 8'h82
`define OPC_STORE_UP 8'h83
`define OPC_PUSH_DIRECT 8'h70
`define OPC_PUSH_INDIRECT 8'h71
`define OPC_CARRY_CLEAR 8'hCF
`define OPC_RETURN 8'hAF
`define OPC_ROTATE_DIRECT 8'h90
`define OPC_ROTATE_INDIRECT 8'h91

`define CYC_STACK_OP 4'h8
`define CYC_SHORT_OP 4'h4
`define CYC_RETURN_SHORT 4'h8
`define CYC_RETURN_LONG 4'hA

`define FLAG_C 3
`define FLAG_Z 2
`define FLAG_S 1
`define FLAG_V 0

`define RETURN_STEP 16'h0002

`endif

/* File: logic/stack_exec_pkg.sv */
// types and decode helpers for the stack, return and rotate executor
// assumes stack_exec_defines.svh is on the include path
`default_nettype none

package stack_exec_pkg;
`include "stack_exec_defines.svh"

    typedef enum logic [3:0] {
        k_none,
        k_read_down,
        k_read_up,
        k_store_down,
        k_store_up,
        k_push,
        k_carry_clear,
        k_return,
        k_rotate
    } op_kind_t;

    function automatic op_kind_t decode_op(input logic [7:0] opc);
        case (opc)
            `OPC_READ_DOWN: decode_op = k_read_down;
            `OPC_READ_UP: decode_op = k_read_up;
            `OPC_STORE_DOWN: decode_op = k_store_down;
            `OPC_STORE_UP: decode_op = k_store_up;
            `OPC_PUSH_DIRECT, `OPC_PUSH_INDIRECT: decode_op = k_push;
            `OPC_CARRY_CLEAR: decode_op = k_carry_clear;
            `OPC_RETURN: decode_op = k_return;
            `OPC_ROTATE_DIRECT, `OPC_ROTATE_INDIRECT: decode_op = k_rotate;
            default: decode_op = k_none;
        endcase
    endfunction

    function automatic logic [3:0] op_cycles(input op_kind_t k, input logic long_return);
        case (k)
            k_carry_clear, k_rotate: op_cycles = `CYC_SHORT_OP;
            k_return: op_cycles = long_return ? `CYC_RETURN_LONG : `CYC_RETURN_SHORT;
            default: op_cycles = `CYC_STACK_OP;
        endcase
    endfunction

    // user stack pointer step, wraps within the byte
    function automatic logic [7:0] step_ptr(input logic [7:0] v, input logic down);
        step_ptr = down ? v - 8'h01 : v + 8'h01;
    endfunction
endpackage

`default_nettype wire

/* File: logic/stack_exec_timer.sv */
// instruction cycle counter: steps 0..len-1 after a start
// assumes len is at least 1 and start only comes while idle
`default_nettype none

module stack_exec_timer (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [3:0] len,
    output logic active,
    output logic [3:0] step,
    output logic last
);
    logic [3:0] len_q;
    logic [3:0] next_len_q;
    logic next_active;
    logic [3:0] next_step;
    logic next_last;

    always_comb begin
        next_len_q = len_q;
        next_active = active;
        next_step = step;
        next_last = last;
        if (!active) begin
            if (start) begin
                next_len_q = len;
                next_active = 1'b1;
                next_step = 4'h0;
                next_last = (len == 4'h1);
            end
        end else if (last) begin
            next_active = 1'b0;
            next_step = 4'h0;
            next_last = 1'b0;
        end else begin
            next_step = step + 4'h1;
            next_last = (step + 4'h1 == len_q - 4'h1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            len_q <= 4'h0;
            active <= 1'b0;
            step <= 4'h0;
            last <= 1'b0;
        end else begin
            len_q <= next_len_q;
            active <= next_active;
            step <= next_step;
            last <= next_last;
        end
    end
endmodule // stack_exec_timer

`default_nettype wire

/* File: logic/rotate_left_unit.sv */
// one-place left rotate with c/z/s/v results
// assumes the flag bus order given by the FLAG_* positions
`default_nettype none
`include "stack_exec_defines.svh"

module rotate_left_unit
    import stack_exec_pkg::*;
(
    input wire logic [7:0] value,
    output logic [7:0] result,
    output logic [3:0] flags_result
);
    always_comb begin
        result = {value[6:0], value[7]};
        flags_result[`FLAG_C] = value[7];
        flags_result[`FLAG_Z] = (result == 8'h00);
        flags_result[`FLAG_S] = result[7];
        // overflow means the sign bit changed
        flags_result[`FLAG_V] = value[7] ^ result[7];
    end
endmodule // rotate_left_unit

`default_nettype wire

/* File: logic/stack_return_rotate_exec.sv */
// executor for user-stack, push, carry-clear, return and rotate-left ops
// assumes an outside register file with combinational read of rf_addr,
// a flags register and the stack pointer bytes held outside this block
//
// What this block does
// - Opcode 92h copies the register the user pointer names to dst, then lowers the pointer by one.
// - Opcode 93h copies the register the user pointer names to dst, then raises the pointer by one.
// - Opcodes 70h/71h lower the stack pointer first, then write the source there, in eight cycles.
// - Opcode 82h lowers the user pointer first, then stores the source where it now points.
// - Opcode 83h raises the user pointer first, then stores the source where it now points.
// - Opcode CFh forces carry to zero in four cycles and leaves the other flags alone.
// - Opcode AFh loads the program counter from the stack word and adds two to the stack pointer.
// - The return takes the high counter byte at the pointer and the low byte at the next location.
// - The return lasts eight cycles or ten in its long variant and touches no flag.
// - Opcodes 90h/91h rotate left one place, old bit 7 going to bit 0 and to carry, in four cycles.
// - Rotate sets zero, sign from bit 7 and overflow on a sign change, clearing each otherwise.
`default_nettype none
`include "stack_exec_defines.svh"

module stack_return_rotate_exec
    import stack_exec_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic exec_start,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand_a,
    input wire logic [7:0] operand_b,
    input wire logic long_return,
    input wire logic [7:0] rf_rdata,
    input wire logic [7:0] stack_pointer_high,
    input wire logic [7:0] stack_pointer_low,
    input wire logic [3:0] flags_in,
    output logic busy,
    output logic done,
    output logic [7:0] rf_addr,
    output logic [7:0] rf_wdata,
    output logic rf_we,
    output logic [15:0] pc_out,
    output logic pc_we,
    output logic [15:0] new_stack_pointer,
    output logic stack_pointer_we,
    output logic [3:0] flags_out,
    output logic flags_we
);
    op_kind_t kind, next_kind;
    logic [7:0] op_a, next_op_a;
    logic [7:0] op_b, next_op_b;
    logic indirect, next_indirect;
    logic long_q, next_long_q;
    logic [7:0] ptr, next_ptr;
    logic [7:0] data, next_data;
    logic [7:0] next_rf_addr;
    logic [7:0] next_rf_wdata;
    logic next_rf_we;
    logic [15:0] next_pc_out;
    logic next_pc_we;
    logic [15:0] next_new_stack_pointer;
    logic next_stack_pointer_we;
    logic [3:0] next_flags_out;
    logic next_flags_we;
    logic start_ok;
    logic [3:0] step;
    logic [15:0] stack_now;
    logic [7:0] rot_result;
    logic [3:0] rot_flags;

    assign stack_now = {stack_pointer_high, stack_pointer_low};
    // unknown opcodes and starts while busy are ignored
    assign start_ok = exec_start && !busy && (decode_op(opcode) != k_none);

    stack_exec_timer timer (
        .clk(clk),
        .rst_b(rst_b),
        .start(start_ok),
        .len(op_cycles(decode_op(opcode), long_return)),
        .active(busy),
        .step(step),
        .last(done)
    );

    rotate_left_unit rotator (
        .value(rf_rdata),
        .result(rot_result),
        .flags_result(rot_flags)
    );

    always_comb begin
        next_kind = kind;
        next_op_a = op_a;
        next_op_b = op_b;
        next_indirect = indirect;
        next_long_q = long_q;
        next_ptr = ptr;
        next_data = data;
        next_rf_addr = rf_addr;
        next_rf_wdata = rf_wdata;
        next_rf_we = 1'b0;
        next_pc_out = pc_out;
        next_pc_we = 1'b0;
        next_new_stack_pointer = new_stack_pointer;
        next_stack_pointer_we = 1'b0;
        next_flags_out = flags_out;
        next_flags_we = 1'b0;
        if (!busy) begin
            if (start_ok) begin
                next_kind = decode_op(opcode);
                next_op_a = operand_a;
                next_op_b = operand_b;
                next_indirect = opcode[0];
                next_long_q = long_return;
            end
        end else begin
            unique case (kind)
                k_none: begin
                end
                k_read_down, k_read_up: begin
                    if (step == 4'h0) begin
                        next_rf_addr = op_a;
                    end else if (step == 4'h1) begin
                        next_ptr = rf_rdata;
                        next_rf_addr = rf_rdata;
                    end else if (step == 4'h2) begin
                        next_rf_addr = op_b;
                        next_rf_wdata = rf_rdata;
                        next_rf_we = 1'b1;
                    end else if (step == 4'h3) begin
                        next_rf_addr = op_a;
                        next_rf_wdata = step_ptr(ptr, kind == k_read_down);
                        next_rf_we = 1'b1;
                    end
                end
                k_store_down, k_store_up: begin
                    if (step == 4'h0) begin
                        next_rf_addr = op_a;
                    end else if (step == 4'h1) begin
                        // pointer is written back before the data store
                        next_ptr = step_ptr(rf_rdata, kind == k_store_down);
                        next_rf_addr = op_a;
                        next_rf_wdata = step_ptr(rf_rdata, kind == k_store_down);
                        next_rf_we = 1'b1;
                    end else if (step == 4'h2) begin
                        next_rf_addr = op_b;
                    end else if (step == 4'h3) begin
                        next_rf_addr = ptr;
                        next_rf_wdata = rf_rdata;
                        next_rf_we = 1'b1;
                    end
                end
                k_push: begin
                    if (step == 4'h0) begin
                        next_rf_addr = op_a;
                    end else if (step == 4'h1) begin
                        if (indirect) begin
                            next_rf_addr = rf_rdata;
                        end
                    end else if (step == 4'h2) begin
                        next_data = rf_rdata;
                        next_new_stack_pointer = stack_now - 16'h0001;
                        next_stack_pointer_we = 1'b1;
                    end else if (step == 4'h3) begin
                        // internal stack lives in the register file, low byte addresses it
                        next_rf_addr = new_stack_pointer[7:0];
                        next_rf_wdata = data;
                        next_rf_we = 1'b1;
                    end
                end
                k_carry_clear: begin
                    if (step == 4'h0) begin
                        next_flags_out = flags_in;
                        next_flags_out[`FLAG_C] = 1'b0;
                        next_flags_we = 1'b1;
                    end
                end
                k_return: begin
                    if (step == 4'h0) begin
                        next_rf_addr = stack_pointer_low;
                    end else if (step == 4'h1) begin
                        next_ptr = rf_rdata;
                        next_rf_addr = stack_pointer_low + 8'h01;
                    end else if (step == 4'h2) begin
                        next_data = rf_rdata;
                    end else if (step == 4'h3) begin
                        next_pc_out = {ptr, data};
                        next_pc_we = 1'b1;
                        next_new_stack_pointer = stack_now + `RETURN_STEP;
                        next_stack_pointer_we = 1'b1;
                    end
                end
                k_rotate: begin
                    if (step == 4'h0) begin
                        next_rf_addr = op_a;
                    end else if (step == 4'h1) begin
                        if (indirect) begin
                            next_rf_addr = rf_rdata;
                        end
                    end else if (step == 4'h2) begin
                        next_rf_wdata = rot_result;
                        next_rf_we = 1'b1;
                        next_flags_out = rot_flags;
                        next_flags_we = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            kind <= k_none;
            op_a <= 8'h00;
            op_b <= 8'h00;
            indirect <= 1'b0;
            long_q <= 1'b0;
            ptr <= 8'h00;
            data <= 8'h00;
            rf_addr <= 8'h00;
            rf_wdata <= 8'h00;
            rf_we <= 1'b0;
            pc_out <= 16'h0000;
            pc_we <= 1'b0;
            new_stack_pointer <= 16'h0000;
            stack_pointer_we <= 1'b0;
            flags_out <= 4'h0;
            flags_we <= 1'b0;
        end else begin
            kind <= next_kind;
            op_a <= next_op_a;
            op_b <= next_op_b;
            indirect <= next_indirect;
            long_q <= next_long_q;
            ptr <= next_ptr;
            data <= next_data;
            rf_addr <= next_rf_addr;
            rf_wdata <= next_rf_wdata;
            rf_we <= next_rf_we;
            pc_out <= next_pc_out;
            pc_we <= next_pc_we;
            new_stack_pointer <= next_new_stack_pointer;
            stack_pointer_we <= next_stack_pointer_we;
            flags_out <= next_flags_out;
            flags_we <= next_flags_we;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    read_down_ptr_a: assert property ((busy && kind == k_read_down && step == 4'h3)
        |-> rf_we && rf_addr == op_b ##1 rf_we && rf_addr == op_a && rf_wdata == ptr - 8'h01)
        else $error("read-down pointer or data write wrong");
    read_up_ptr_a: assert property ((busy && kind == k_read_up && step == 4'h3)
        |-> rf_wdata == $past(rf_rdata) ##1 rf_we && rf_addr == op_a && rf_wdata == ptr + 8'h01)
        else $error("read-up pointer or data write wrong");
    push_order_a: assert property ((busy && kind == k_push && $rose(stack_pointer_we))
        |-> new_stack_pointer == $past(stack_now) - 16'h0001
        ##1 rf_we && rf_addr == new_stack_pointer[7:0] && rf_wdata == data)
        else $error("push order or target wrong");
    indirect_addr_a: assert property ((busy && (kind == k_push || kind == k_rotate) && step == 4'h2)
        |-> rf_addr == (indirect ? $past(rf_rdata) : op_a))
        else $error("operand address wrong");
    store_down_a: assert property ((busy && kind == k_store_down && step == 4'h2)
        |-> rf_we && rf_addr == op_a && rf_wdata == $past(rf_rdata) - 8'h01
        ##2 rf_we && rf_addr == ptr)
        else $error("store-down order wrong");
    store_up_a: assert property ((busy && kind == k_store_up && step == 4'h2)
        |-> rf_we && rf_wdata == $past(rf_rdata) + 8'h01 ##2 rf_we && rf_addr == ptr)
        else $error("store-up order wrong");
    carry_clear_a: assert property ((busy && kind == k_carry_clear && step == 4'h1)
        |-> flags_we && !flags_out[`FLAG_C] && flags_out[2:0] == $past(flags_in[2:0]))
        else $error("carry clear wrong");
    short_len_a: assert property ((done && (kind == k_carry_clear || kind == k_rotate))
        |-> step == 4'h3)
        else $error("short op length wrong");
    return_pc_a: assert property ((busy && kind == k_return && step == 4'h1)
        |-> rf_addr == stack_pointer_low ##1 rf_addr == stack_pointer_low + 8'h01
        ##2 pc_we && pc_out == {$past(rf_rdata, 3), $past(rf_rdata, 2)}
        && new_stack_pointer == stack_now + 16'h0002)
        else $error("return pc or pointer wrong");
    return_len_a: assert property ((done && kind == k_return)
        |-> step == (long_q ? 4'h9 : 4'h7))
        else $error("return length wrong");
    flags_quiet_a: assert property (flags_we |-> kind == k_carry_clear || kind == k_rotate)
        else $error("flags written by a flagless op");
    rotate_result_a: assert property ((busy && kind == k_rotate && step == 4'h3)
        |-> rf_we && rf_wdata == {$past(rf_rdata[6:0]), $past(rf_rdata[7])}
        && flags_out[`FLAG_C] == $past(rf_rdata[7]) && done)
        else $error("rotate result wrong");
    rotate_flags_a: assert property ((flags_we && kind == k_rotate)
        |-> flags_out[`FLAG_Z] == (rf_wdata == 8'h00) && flags_out[`FLAG_S] == rf_wdata[7]
        && flags_out[`FLAG_V] == (rf_wdata[7] ^ rf_wdata[0]))
        else $error("rotate flags wrong");

    return_done_c: cover property (done && kind == k_return && long_q);
    push_wrap_c: cover property (stack_pointer_we && kind == k_push && new_stack_pointer == 16'hFFFF);
    rotate_carry_c: cover property (flags_we && kind == k_rotate && flags_out[`FLAG_C]);
    read_down_c: cover property (done && kind == k_read_down);
    store_up_c: cover property (done && kind == k_store_up);
endmodule // stack_return_rotate_exec

`default_nettype wire

/* File: tb/test_stack_return_rotate_exec.sv */
// self-checking bench for the stack, return and rotate executor
// assumes the design package and defines header are compiled first; the bench models
// the register file, stack pointer bytes, flags and program counter outside the block
`default_nettype none

`include "stack_exec_defines.svh"

`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end

module test_stack_return_rotate_exec;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk;
    logic rst_b;
    logic exec_start;
    logic [7:0] opcode;
    logic [7:0] operand_a;
    logic [7:0] operand_b;
    logic long_return;
    logic [7:0] rf_rdata;
    logic [7:0] stack_pointer_high;
    logic [7:0] stack_pointer_low;
    logic [3:0] flag_reg;
    logic busy;
    logic done;
    logic [7:0] rf_addr;
    logic [7:0] rf_wdata;
    logic rf_we;
    logic [15:0] pc_out;
    logic pc_we;
    logic [15:0] new_stack_pointer;
    logic stack_pointer_we;
    logic [3:0] flags_out;
    logic flags_we;
    logic [15:0] pc;
    logic [7:0] rf [0:255];
    int error_cnt;
    int samples_checked;

    stack_return_rotate_exec DUT (
        .clk(clk), .rst_b(rst_b), .exec_start(exec_start), .opcode(opcode),
        .operand_a(operand_a), .operand_b(operand_b), .long_return(long_return),
        .rf_rdata(rf_rdata), .stack_pointer_high(stack_pointer_high),
        .stack_pointer_low(stack_pointer_low), .flags_in(flag_reg), .busy(busy),
        .done(done), .rf_addr(rf_addr), .rf_wdata(rf_wdata), .rf_we(rf_we),
        .pc_out(pc_out), .pc_we(pc_we), .new_stack_pointer(new_stack_pointer),
        .stack_pointer_we(stack_pointer_we), .flags_out(flags_out), .flags_we(flags_we)
    );

    // outside state: read is combinational, strobes land at the next edge
    assign rf_rdata = rf[rf_addr];
    always @(posedge clk) begin
        if (rf_we === 1'b1) rf[rf_addr] <= rf_wdata;
        if (stack_pointer_we === 1'b1) {stack_pointer_high, stack_pointer_low} <= new_stack_pointer;
        if (flags_we === 1'b1) flag_reg <= flags_out;
        if (pc_we === 1'b1) pc <= pc_out;
    end

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic wrap_up;
        $display("errors %0d, comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // called at a falling edge; returns at a falling edge with busy low
    task automatic run_op(input logic [7:0] opc, input logic [7:0] a, input logic [7:0] b,
                          input logic long_sel, input int n);
        int cnt;
        cnt = 1;
        opcode = opc;
        operand_a = a;
        operand_b = b;
        long_return = long_sel;
        exec_start = 1'b1;
        @(negedge clk);
        exec_start = 1'b0;
        while (done !== 1'b1 && cnt < 40) begin
            @(negedge clk);
            cnt++;
        end
        `CHK(cnt, n)
        @(negedge clk);
        `CHK(busy, 1'b0)
    endtask

    task automatic t_read_down;
        rf[8'h00] = 8'h42;
        rf[8'h42] = 8'h6F;
        rf[8'h02] = 8'h70;
        flag_reg = 4'hA;
        run_op(`OPC_READ_DOWN, 8'h00, 8'h02, 1'b0, 8);
        `CHK(rf[8'h02], 8'h6F)
        `CHK(rf[8'h00], 8'h41)
        `CHK(flag_reg, 4'hA)
    endtask

    task automatic t_read_up;
        rf[8'h05] = 8'hFF;
        rf[8'hFF] = 8'h70;
        run_op(`OPC_READ_UP, 8'h05, 8'h02, 1'b0, 8);
        `CHK(rf[8'h02], 8'h70)
        `CHK(rf[8'h05], 8'h00)
        `CHK(flag_reg, 4'hA)
    endtask

    task automatic t_push;
        {stack_pointer_high, stack_pointer_low} = 16'h0000;
        rf[8'h40] = 8'h4F;
        rf[8'h4F] = 8'hAA;
        run_op(`OPC_PUSH_DIRECT, 8'h40, 8'h00, 1'b0, 8);
        `CHK(rf[8'hFF], 8'h4F)
        `CHK({stack_pointer_high, stack_pointer_low}, 16'hFFFF)
        {stack_pointer_high, stack_pointer_low} = 16'h0010;
        run_op(`OPC_PUSH_INDIRECT, 8'h40, 8'h00, 1'b0, 8);
        `CHK(rf[8'h0F], 8'hAA)
        `CHK(rf[8'h40], 8'h4F)
        `CHK({stack_pointer_high, stack_pointer_low}, 16'h000F)
        `CHK(flag_reg, 4'hA)
    endtask

    task automatic t_store;
        rf[8'h00] = 8'h03;
        rf[8'h01] = 8'h05;
        run_op(`OPC_STORE_DOWN, 8'h00, 8'h01, 1'b0, 8);
        `CHK(rf[8'h00], 8'h02)
        `CHK(rf[8'h02], 8'h05)
        rf[8'h00] = 8'h03;
        rf[8'h01] = 8'h07;
        run_op(`OPC_STORE_UP, 8'h00, 8'h01, 1'b0, 8);
        `CHK(rf[8'h00], 8'h04)
        `CHK(rf[8'h04], 8'h07)
        `CHK(flag_reg, 4'hA)
    endtask

    task automatic t_carry_clear;
        flag_reg = 4'hF;
        run_op(`OPC_CARRY_CLEAR, 8'h00, 8'h00, 1'b0, 4);
        `CHK(flag_reg, 4'h7)
        flag_reg = 4'h2;
        run_op(`OPC_CARRY_CLEAR, 8'h00, 8'h00, 1'b0, 4);
        `CHK(flag_reg, 4'h2)
    endtask

    task automatic t_return;
        {stack_pointer_high, stack_pointer_low} = 16'h12FC;
        rf[8'hFC] = 8'h10;
        rf[8'hFD] = 8'h1A;
        flag_reg = 4'h5;
        run_op(`OPC_RETURN, 8'h00, 8'h00, 1'b0, 8);
        `CHK(pc, 16'h101A)
        `CHK({stack_pointer_high, stack_pointer_low}, 16'h12FE)
        // low byte of the pair sits past the 8-bit wrap
        {stack_pointer_high, stack_pointer_low} = 16'h12FF;
        rf[8'hFF] = 8'h23;
        rf[8'h00] = 8'h45;
        run_op(`OPC_RETURN, 8'h00, 8'h00, 1'b1, 10);
        `CHK(pc, 16'h2345)
        `CHK({stack_pointer_high, stack_pointer_low}, 16'h1301)
        `CHK(flag_reg, 4'h5)
    endtask

    task automatic t_rotate;
        rf[8'h00] = 8'hAA;
        flag_reg = 4'h6;
        run_op(`OPC_ROTATE_DIRECT, 8'h00, 8'h00, 1'b0, 4);
        `CHK(rf[8'h00], 8'h55)
        `CHK(flag_reg, 4'h9)
        rf[8'h01] = 8'h02;
        rf[8'h02] = 8'h17;
        flag_reg = 4'hF;
        run_op(`OPC_ROTATE_INDIRECT, 8'h01, 8'h00, 1'b0, 4);
        `CHK(rf[8'h02], 8'h2E)
        `CHK(flag_reg, 4'h0)
        rf[8'h03] = 8'h00;
        run_op(`OPC_ROTATE_DIRECT, 8'h03, 8'h00, 1'b0, 4);
        `CHK(flag_reg, 4'h4)
        rf[8'h03] = 8'h40;
        run_op(`OPC_ROTATE_DIRECT, 8'h03, 8'h00, 1'b0, 4);
        `CHK(rf[8'h03], 8'h80)
        `CHK(flag_reg, 4'h3)
    endtask

    // a start while busy and an unknown opcode must both be ignored
    task automatic t_refused;
        {stack_pointer_high, stack_pointer_low} = 16'h0020;
        flag_reg = 4'hF;
        run_op(`OPC_CARRY_CLEAR, 8'h40, 8'h00, 1'b0, 4);
        opcode = `OPC_CARRY_CLEAR;
        exec_start = 1'b1;
        @(negedge clk);
        opcode = `OPC_PUSH_DIRECT;
        repeat (2) @(negedge clk);
        exec_start = 1'b0;
        repeat (4) @(negedge clk);
        `CHK({stack_pointer_high, stack_pointer_low}, 16'h0020)
        `CHK(rf[8'h1F], 8'h00)
        opcode = 8'hFF;
        exec_start = 1'b1;
        @(negedge clk);
        exec_start = 1'b0;
        repeat (3) begin
            @(negedge clk);
            `CHK(busy, 1'b0)
        end
        `CHK(flag_reg, 4'h7)
    endtask

    initial begin
        #(5000 * 10);
        error_cnt++;
        wrap_up;
    end

    initial begin
        error_cnt = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        exec_start = 1'b0;
        opcode = 8'h00;
        operand_a = 8'h00;
        operand_b = 8'h00;
        long_return = 1'b0;
        {stack_pointer_high, stack_pointer_low} = 16'h0000;
        flag_reg = 4'h0;
        pc = 16'h0000;
        for (int i = 0; i < 256; i++) rf[i] = 8'h00;
        repeat (2) @(negedge clk);
        `CHK({busy, done, rf_we, pc_we, stack_pointer_we, flags_we}, 6'h00)
        rst_b = 1'b1;
        t_read_down();
        t_read_up();
        t_push();
        t_store();
        t_carry_clear();
        t_return();
        t_rotate();
        t_refused();
        wrap_up;
    end
endmodule // test_stack_return_rotate_exec

`default_nettype wire
